// file: rtl/beh_consts.vh
`ifndef BEH_CONSTS_VH
`define BEH_CONSTS_VH
// register byte offsets
`define BEH_OFF_CSR 8'h00
`define BEH_OFF_MCTL 8'h04
`define BEH_OFF_VSTAT 8'h08
`define BEH_OFF_PSTAT 8'h0c
`define BEH_OFF_VEN 8'h10
`define BEH_OFF_PEN 8'h14
`define BEH_OFF_VAM 8'h18
`define BEH_OFF_VADR 8'h1c
`define BEH_OFF_PCMD 8'h20
`define BEH_OFF_PADR 8'h24
// command/status fields
`define BEH_CSR_PRE 6
`define BEH_CSR_SEE 8
`define BEH_CSR_DPD 24
`define BEH_CSR_STA 27
`define BEH_CSR_RTA 28
`define BEH_CSR_RMA 29
`define BEH_CSR_SSE 30
`define BEH_CSR_DPE 31
// interrupt status / enable fields
`define BEH_SRC_VME 0
`define BEH_SRC_PERR 1
// log fields
`define BEH_LOG_IACK 6
`define BEH_LOG_MERR 7
// vme cycle kinds
`define BEH_CYC_SINGLE 2'h0
`define BEH_CYC_BLT 2'h1
`define BEH_CYC_MBLT 2'h2
// flush boundaries as address-bit positions
`define BEH_BND_256 8
`define BEH_BND_2K 11
`define BEH_BEAT_BYTES 32'h0000_0004
// burst align base position (32 bytes at code 0)
`define BEH_BALIGN_BASE 5'h05
`define BEH_RST_WORD 32'h0000_0000
`endif

// file: rtl/beh_top.v
// Decided for this implementation: the placing of the registers and the APB register port.
`include "beh_consts.vh"
`default_nettype none
module beh_top (
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // coupled cycles
  input wire v2p_cpl_tabort,
  input wire v2p_cpl_mabort,
  input wire p2v_cpl_berr,
  output reg vme_berr_q,
  output reg pci_tabort_q,
  // posted write acceptance
  input wire rx_store,
  input wire tx_store,
  output wire rx_wr_ack,
  output wire tx_wr_ack,
  // vme side of posted writes (pci initiated, via tx fifo)
  input wire vme_addr_issue,
  input wire vme_blk_cont,
  input wire [31:0] vme_addr,
  input wire [5:0] vme_am,
  input wire vme_iack_n,
  input wire vme_pw_err,
  input wire [31:0] tx_txn_end,
  output reg tx_flush_q,
  output reg [31:0] tx_flush_end_q,
  // pci side of posted writes (vme initiated, via rx fifo)
  input wire pci_addr_issue,
  input wire [31:0] pci_addr,
  input wire [3:0] pci_cmd,
  input wire [1:0] rx_cycle,
  input wire pci_pw_err,
  output reg rx_flush_q,
  output reg [31:0] rx_flush_end_q,
  // error interrupt requests
  output wire vme_err_irq,
  output wire pci_err_irq,
  // prefetched reads
  input wire pf_start,
  input wire [31:0] pf_addr,
  input wire pf_first_ack,
  input wire pf_pci_err,
  output reg pf_req_q,
  output reg [31:0] pf_start_q,
  output reg [31:0] pf_end_q,
  output reg pf_dtack_q,
  // pci parity
  input wire [63:0] ad_in,
  input wire [7:0] cbe_in,
  input wire bus64,
  output reg par_q,
  output reg par64_q,
  input wire chk_data,
  input wire chk_addr,
  input wire as_master,
  input wire par_in,
  input wire par64_in,
  input wire perr_in_n,
  input wire tgt_decode_hit,
  output wire devsel_claim,
  output reg perr_o_n,
  output reg perr_oe_n,
  output reg serr_o_n,
  output reg serr_oe_n
);

// ----------------------------------------
// apb decode
// ----------------------------------------
wire wr_en;
wire rd_en;
reg hit;
// zero wait state: every access completes in its access phase
assign pready = 1'b1;
assign pslverr = psel & penable & ~hit;
assign wr_en = psel & penable & pwrite & hit;
assign rd_en = psel & penable & ~pwrite;

// ----------------------------------------
// command/status register
// ----------------------------------------
reg pre_q;
reg see_q;
reg dpd_q;
reg sta_q;
reg rta_q;
reg rma_q;
reg sse_q;
reg dpe_q;
wire csr_wr;
wire [31:0] w1c;
assign csr_wr = wr_en && (paddr == `BEH_OFF_CSR);
// status bits clear only where software writes a one
assign w1c = csr_wr ? pwdata : `BEH_RST_WORD;

// ----------------------------------------
// parity generation and check
// ----------------------------------------
wire par_lo;
wire par_hi;
wire perr_lo;
wire perr_hi;
wire data_perr;
wire addr_perr;
// even parity: ones in data plus par is even
assign par_lo = ^{cbe_in[3:0], ad_in[31:0]};
assign par_hi = ^{cbe_in[7:4], ad_in[63:32]};
assign perr_lo = par_lo ^ par_in;
assign perr_hi = bus64 & (par_hi ^ par64_in);
assign data_perr = chk_data & (perr_lo | perr_hi);
assign addr_perr = chk_addr & perr_lo;
// an address parity error never gets a devsel
assign devsel_claim = tgt_decode_hit & ~addr_perr;

// parity outputs are sent the cycle after the bus value
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    par_q <= 1'b0;
    par64_q <= 1'b0;
  end else begin
    par_q <= par_lo;
    par64_q <= bus64 & par_hi;
  end
end

// perr and serr drivers: open drain, oe low while driving
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    perr_o_n <= 1'b1;
    perr_oe_n <= 1'b1;
    serr_o_n <= 1'b1;
    serr_oe_n <= 1'b1;
  end else begin
    perr_o_n <= ~(data_perr & pre_q);
    perr_oe_n <= ~(data_perr & pre_q);
    serr_o_n <= ~(addr_perr & pre_q & see_q);
    serr_oe_n <= ~(addr_perr & pre_q & see_q);
  end
end

// csr flags: set wins over a clear in the same cycle
// parity never touches interrupts; past the flags it only gates devsel_claim and the perr/serr pins
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    pre_q <= 1'b0;
    see_q <= 1'b0;
    dpd_q <= 1'b0;
    sta_q <= 1'b0;
    rta_q <= 1'b0;
    rma_q <= 1'b0;
    sse_q <= 1'b0;
    dpe_q <= 1'b0;
  end else begin
    if (csr_wr) begin
      pre_q <= pwdata[`BEH_CSR_PRE];
      see_q <= pwdata[`BEH_CSR_SEE];
    end
    dpe_q <= (data_perr | addr_perr) | (dpe_q & ~w1c[`BEH_CSR_DPE]);
    // master: own perr on read, or perr received on write
    dpd_q <= (pre_q & as_master & (data_perr | ~perr_in_n))
      | (dpd_q & ~w1c[`BEH_CSR_DPD]);
    sse_q <= (addr_perr & pre_q & see_q)
      | (sse_q & ~w1c[`BEH_CSR_SSE]);
    rta_q <= v2p_cpl_tabort | (rta_q & ~w1c[`BEH_CSR_RTA]);
    rma_q <= v2p_cpl_mabort | (rma_q & ~w1c[`BEH_CSR_RMA]);
    sta_q <= p2v_cpl_berr | (sta_q & ~w1c[`BEH_CSR_STA]);
  end
end

// ----------------------------------------
// coupled cycle error translation
// ----------------------------------------
// one-cycle terminations; nothing here feeds the logs
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    vme_berr_q <= 1'b0;
    pci_tabort_q <= 1'b0;
  end else begin
    vme_berr_q <= v2p_cpl_tabort | v2p_cpl_mabort;
    pci_tabort_q <= p2v_cpl_berr;
  end
end

// ----------------------------------------
// posted write acknowledge
// ----------------------------------------
// ack as soon as the beat is in the fifo, not at the target
assign rx_wr_ack = rx_store;
assign tx_wr_ack = tx_store;

// ----------------------------------------
// last issued address trackers
// ----------------------------------------
reg [31:0] vme_last_q;
reg [31:0] pci_last_q;
// block continuation beats keep the block start address
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    vme_last_q <= `BEH_RST_WORD;
    pci_last_q <= `BEH_RST_WORD;
  end else begin
    if (vme_addr_issue && !vme_blk_cont)
      vme_last_q <= vme_addr;
    if (pci_addr_issue)
      pci_last_q <= pci_addr;
  end
end
// an error in the issue cycle itself logs the new address
wire [31:0] vme_eaddr;
wire [31:0] pci_eaddr;
assign vme_eaddr = (vme_addr_issue && !vme_blk_cont) ? vme_addr : vme_last_q;
assign pci_eaddr = pci_addr_issue ? pci_addr : pci_last_q;

// ----------------------------------------
// interrupt status and enable, one per destination bus
// ----------------------------------------
reg [1:0] stat_q [0:1];
reg [1:0] en_q [0:1];
wire [1:0] irq;
wire [1:0] ack_v;
wire [1:0] ack_p;
wire v_log;
wire p_log;
genvar g;
generate
  for (g = 0; g < 2; g = g + 1) begin : g_dst
    wire st_wr;
    wire en_wr;
    assign st_wr = wr_en && (paddr == (g ? `BEH_OFF_PSTAT : `BEH_OFF_VSTAT));
    assign en_wr = wr_en && (paddr == (g ? `BEH_OFF_PEN : `BEH_OFF_VEN));
    assign ack_v[g] = st_wr & pwdata[`BEH_SRC_VME] & stat_q[g][`BEH_SRC_VME];
    assign ack_p[g] = st_wr & pwdata[`BEH_SRC_PERR] & stat_q[g][`BEH_SRC_PERR];
    // status only set where the source is enabled for that bus
    always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        stat_q[g] <= 2'h0;
        en_q[g] <= 2'h0;
      end else begin
        if (en_wr)
          en_q[g] <= pwdata[1:0];
        stat_q[g][`BEH_SRC_VME] <= (v_log & en_q[g][`BEH_SRC_VME])
          | (stat_q[g][`BEH_SRC_VME] & ~ack_v[g]);
        stat_q[g][`BEH_SRC_PERR] <= (p_log & en_q[g][`BEH_SRC_PERR])
          | (stat_q[g][`BEH_SRC_PERR] & ~ack_p[g]);
      end
    end
    assign irq[g] = |stat_q[g];
  end
endgenerate
assign vme_err_irq = irq[0];
assign pci_err_irq = irq[1];

// ----------------------------------------
// vme posted write error log
// ----------------------------------------
reg vfrz_q;
reg vmerr_q;
reg viack_q;
reg [5:0] vam_q;
reg [31:0] vadr_q;
// frozen log ignores new errors; the ack reopens it
assign v_log = vme_pw_err & ~vfrz_q;
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    vfrz_q <= 1'b0;
    vmerr_q <= 1'b0;
    viack_q <= 1'b0;
    vam_q <= 6'h00;
    vadr_q <= `BEH_RST_WORD;
  end else begin
    if (v_log) begin
      vfrz_q <= 1'b1;
      vmerr_q <= 1'b0;
      vam_q <= vme_am;
      viack_q <= ~vme_iack_n;
      vadr_q <= vme_eaddr;
    end else begin
      if (|ack_v)
        vfrz_q <= 1'b0;
      // a second error before the ack is remembered
      if (vme_pw_err)
        vmerr_q <= 1'b1;
    end
  end
end

// ----------------------------------------
// pci posted write error log
// ----------------------------------------
reg pfrz_q;
reg pmerr_q;
reg [3:0] pcmd_q;
reg [31:0] padr_q;
assign p_log = pci_pw_err & ~pfrz_q;
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    pfrz_q <= 1'b0;
    pmerr_q <= 1'b0;
    pcmd_q <= 4'h0;
    padr_q <= `BEH_RST_WORD;
  end else begin
    if (p_log) begin
      pfrz_q <= 1'b1;
      pmerr_q <= 1'b0;
      pcmd_q <= pci_cmd;
      padr_q <= pci_eaddr;
    end else begin
      if (|ack_p)
        pfrz_q <= 1'b0;
      if (pci_pw_err)
        pmerr_q <= 1'b1;
    end
  end
end

// ----------------------------------------
// fifo purge after a posted write error
// ----------------------------------------
// purge happens even when the log is frozen: the data is bad
wire [31:0] tx_bnd;
reg [31:0] rx_bnd;
assign tx_bnd = ((vme_eaddr >> `BEH_BND_256) + 32'h1) << `BEH_BND_256;
always @* begin
  case (rx_cycle)
    `BEH_CYC_BLT:
      rx_bnd = ((pci_eaddr >> `BEH_BND_256) + 32'h1) << `BEH_BND_256;
    `BEH_CYC_MBLT:
      rx_bnd = ((pci_eaddr >> `BEH_BND_2K) + 32'h1) << `BEH_BND_2K;
    default:
      rx_bnd = pci_eaddr + `BEH_BEAT_BYTES;
  endcase
end
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    tx_flush_q <= 1'b0;
    tx_flush_end_q <= `BEH_RST_WORD;
    rx_flush_q <= 1'b0;
    rx_flush_end_q <= `BEH_RST_WORD;
  end else begin
    tx_flush_q <= vme_pw_err;
    rx_flush_q <= pci_pw_err;
    if (vme_pw_err)
      tx_flush_end_q <= (tx_txn_end < tx_bnd) ? tx_txn_end : tx_bnd;
    if (pci_pw_err)
      rx_flush_end_q <= rx_bnd;
  end
end

// ----------------------------------------
// prefetched block read
// ----------------------------------------
reg [1:0] burst_align_q;
wire [4:0] sh;
wire [31:0] pf_end;
assign sh = `BEH_BALIGN_BASE + {3'h0, burst_align_q};
assign pf_end = ((pf_addr >> sh) + 32'h1) << sh;
// pci errors during prefetch are not mapped: no dtack and no
// berr, so the vme bus timer ends the cycle
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    pf_req_q <= 1'b0;
    pf_start_q <= `BEH_RST_WORD;
    pf_end_q <= `BEH_RST_WORD;
    pf_dtack_q <= 1'b0;
  end else begin
    pf_req_q <= pf_start;
    if (pf_start) begin
      pf_start_q <= pf_addr;
      pf_end_q <= pf_end;
    end
    pf_dtack_q <= pf_first_ack & ~pf_pci_err;
  end
end

// master control: burst align size
always @(posedge pclk or negedge presetn) begin
  if (!presetn)
    burst_align_q <= 2'h0;
  else if (wr_en && (paddr == `BEH_OFF_MCTL))
    burst_align_q <= pwdata[1:0];
end

// ----------------------------------------
// apb read mux
// ----------------------------------------
always @* begin
  hit = 1'b1;
  prdata = `BEH_RST_WORD;
  case (paddr)
    `BEH_OFF_CSR: begin
      prdata[`BEH_CSR_PRE] = pre_q;
      prdata[`BEH_CSR_SEE] = see_q;
      prdata[`BEH_CSR_DPD] = dpd_q;
      prdata[`BEH_CSR_STA] = sta_q;
      prdata[`BEH_CSR_RTA] = rta_q;
      prdata[`BEH_CSR_RMA] = rma_q;
      prdata[`BEH_CSR_SSE] = sse_q;
      prdata[`BEH_CSR_DPE] = dpe_q;
    end
    `BEH_OFF_MCTL: prdata[1:0] = burst_align_q;
    `BEH_OFF_VSTAT: prdata[1:0] = stat_q[0];
    `BEH_OFF_PSTAT: prdata[1:0] = stat_q[1];
    `BEH_OFF_VEN: prdata[1:0] = en_q[0];
    `BEH_OFF_PEN: prdata[1:0] = en_q[1];
    `BEH_OFF_VAM: begin
      prdata[5:0] = vam_q;
      prdata[`BEH_LOG_IACK] = viack_q;
      prdata[`BEH_LOG_MERR] = vmerr_q;
    end
    `BEH_OFF_VADR: prdata = vadr_q;
    `BEH_OFF_PCMD: begin
      prdata[3:0] = pcmd_q;
      prdata[`BEH_LOG_MERR] = pmerr_q;
    end
    `BEH_OFF_PADR: prdata = padr_q;
    default: hit = 1'b0;
  endcase
  if (!rd_en)
    prdata = `BEH_RST_WORD;
end

endmodule
`default_nettype wire

// file: sim/beh_chk_props.sv
`default_nettype none
// ----
// port checks
// ----
module beh_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic v2p_cpl_tabort,
  input wire logic v2p_cpl_mabort,
  input wire logic p2v_cpl_berr,
  input wire logic vme_berr_q,
  input wire logic pci_tabort_q,
  input wire logic rx_store,
  input wire logic tx_store,
  input wire logic rx_wr_ack,
  input wire logic tx_wr_ack,
  input wire logic vme_pw_err,
  input wire logic tx_flush_q,
  input wire logic pci_pw_err,
  input wire logic rx_flush_q,
  input wire logic pf_first_ack,
  input wire logic pf_pci_err,
  input wire logic pf_dtack_q,
  input wire logic [63:0] ad_in,
  input wire logic [7:0] cbe_in,
  input wire logic bus64,
  input wire logic par_q,
  input wire logic par64_q,
  input wire logic par_in,
  input wire logic chk_addr,
  input wire logic devsel_claim
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // a first beat that came back clean
  sequence s_beat_ok;
    pf_first_ack && !pf_pci_err;
  endsequence
  // an address phase whose parity does not add up to even
  sequence s_bad_addr;
    chk_addr && (^{ad_in[31:0], cbe_in[3:0], par_in});
  endsequence
  property p_berr; v2p_cpl_tabort || v2p_cpl_mabort |=> vme_berr_q; endproperty
  a_berr: assert property (p_berr) else $error("abort not ended");
  property p_tab; p2v_cpl_berr |=> pci_tabort_q; endproperty
  a_tab: assert property (p_tab) else $error("berr not ended");
  property p_ack; rx_wr_ack == rx_store && tx_wr_ack == tx_store; endproperty
  a_ack: assert property (p_ack) else $error("store not acked");
  property p_txf; vme_pw_err |=> tx_flush_q; endproperty
  a_txf: assert property (p_txf) else $error("no tx purge");
  property p_rxf; pci_pw_err |=> rx_flush_q; endproperty
  a_rxf: assert property (p_rxf) else $error("no rx purge");
  property p_dtk; s_beat_ok |=> pf_dtack_q; endproperty
  a_dtk: assert property (p_dtk) else $error("no dtack");
  property p_nod; pf_pci_err |=> !pf_dtack_q; endproperty
  a_nod: assert property (p_nod) else $error("dtack on error");
  property p_dev; s_bad_addr |-> !devsel_claim; endproperty
  a_dev: assert property (p_dev) else $error("claimed bad address");
  // parity of the bus as it stood one cycle earlier
  property p_par;
    1'b1 |=> par_q == $past(^{ad_in[31:0], cbe_in[3:0]})
      && par64_q == $past(bus64 & (^{ad_in[63:32], cbe_in[7:4]}));
  endproperty
  a_par: assert property (p_par) else $error("parity wrong");
endmodule
`default_nettype wire

// file: sim/beh_pci_agent.sv
`default_nettype none
// ----
// pci agent sending phases with broken parity
// ----
module beh_pci_agent (
  input wire logic pclk,
  input wire logic send_bad,
  input wire logic addr_ph,
  output logic [63:0] ad_in,
  output logic [7:0] cbe_in,
  output logic par_in,
  output logic par64_in,
  output logic chk_data,
  output logic chk_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ad_in = '0;
    cbe_in = '0;
    chk_data = 1'b0;
    chk_addr = 1'b0;
  end
  // idle lines flip each cycle so stale data never looks valid
  always @(posedge pclk) begin
    // odd count of ones in both halves, so par_q goes high, and par64_q too when bus64 is set
    ad_in <= send_bad ? 64'h0123_4567_89ab_cdee : ~ad_in;
    cbe_in <= send_bad ? 8'h1f : ~cbe_in;
    chk_data <= send_bad & ~addr_ph;
    chk_addr <= send_bad & addr_ph;
  end
  // even parity; only par_in is turned odd, and only while a phase is checked
  assign par_in = ^{ad_in[31:0], cbe_in[3:0], chk_data | chk_addr};
  assign par64_in = ^{ad_in[63:32], cbe_in[7:4]};
endmodule
`default_nettype wire

// file: sim/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, go, pa_ap, as_master, err, b64, perr_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd, vme_addr, pci_addr, pf_addr, tx_txn_end;
  logic [10:0] evs;
  logic [14:0] fl;
  logic [31:0] xe [3] = '{32'h5128, 32'h5200, 32'h5800};
  int failures, check_count;
  wire v2p_cpl_tabort, v2p_cpl_mabort, p2v_cpl_berr, rx_store, tx_store, vme_addr_issue;
  wire vme_pw_err, pci_addr_issue, pci_pw_err, pf_start, pf_first_ack;
  wire vme_blk_cont, vme_iack_n, pf_pci_err, par_in, par64_in, chk_data, chk_addr;
  wire [5:0] vme_am;
  wire [3:0] pci_cmd;
  wire [1:0] rx_cycle;
  wire [63:0] ad_in;
  wire [7:0] cbe_in;
  wire [31:0] prdata, tx_flush_end_q, rx_flush_end_q, pf_end_q, pf_start_q;
  wire pready, pslverr, vme_berr_q, pci_tabort_q, rx_wr_ack, tx_wr_ack, tx_flush_q;
  wire rx_flush_q, vme_err_irq, pci_err_irq, pf_req_q, pf_dtack_q, par_q, par64_q;
  wire devsel_claim, perr_o_n, perr_oe_n, serr_o_n, serr_oe_n;
  localparam logic [10:0] e_ta = 11'h400, e_ma = 11'h200, e_be = 11'h100, e_rs = 11'h080;
  localparam logic [10:0] e_ts = 11'h040, e_vi = 11'h020, e_ve = 11'h010, e_pi = 11'h008;
  localparam logic [10:0] e_pe = 11'h004, e_ps = 11'h002, e_fa = 11'h001;
  // event pulses and their qualifiers travel as two bundles
  assign {v2p_cpl_tabort, v2p_cpl_mabort, p2v_cpl_berr, rx_store, tx_store, vme_addr_issue,
    vme_pw_err, pci_addr_issue, pci_pw_err, pf_start, pf_first_ack} = evs;
  assign {vme_blk_cont, vme_iack_n, vme_am, pci_cmd, rx_cycle, pf_pci_err} = fl;
  beh_top dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .v2p_cpl_tabort, .v2p_cpl_mabort, .p2v_cpl_berr, .vme_berr_q, .pci_tabort_q,
    .rx_store, .tx_store, .rx_wr_ack, .tx_wr_ack, .vme_addr_issue, .vme_blk_cont,
    .vme_addr, .vme_am, .vme_iack_n, .vme_pw_err, .tx_txn_end, .tx_flush_q, .tx_flush_end_q,
    .pci_addr_issue, .pci_addr, .pci_cmd, .rx_cycle, .pci_pw_err, .rx_flush_q, .rx_flush_end_q,
    .vme_err_irq, .pci_err_irq, .pf_start, .pf_addr, .pf_first_ack, .pf_pci_err, .pf_req_q,
    .pf_start_q, .pf_end_q, .pf_dtack_q, .ad_in, .cbe_in, .bus64(b64), .par_q, .par64_q,
    .chk_data, .chk_addr, .as_master, .par_in, .par64_in, .perr_in_n(perr_n),
    .tgt_decode_hit(1'b1), .devsel_claim, .perr_o_n, .perr_oe_n, .serr_o_n, .serr_oe_n
  );
  beh_pci_agent u_agent (
    .pclk, .send_bad(go), .addr_ph(pa_ap), .ad_in, .cbe_in, .par_in, .par64_in,
    .chk_data, .chk_addr
  );
  // ----
  // bus and compare helpers
  // ----
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle budget here: only the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask
  // one cycle of events; qualifiers hold until the next call
  task ev(input logic [10:0] m, input logic [31:0] a, input logic [14:0] f,
    input logic [31:0] t);
    @(posedge pclk);
    evs <= m;
    vme_addr <= a;
    pci_addr <= a;
    pf_addr <= a;
    fl <= f;
    tx_txn_end <= t;
    #1;
    chk(32'({rx_wr_ack, tx_wr_ack}), 32'({m[7], m[6]}));
    @(posedge pclk);
    evs <= '0;
    #1;
  endtask
  // ----
  // scenarios
  // ----
  task s_cpl;
    chk(32'({perr_oe_n, serr_oe_n}), 3);
    rdc(8'h00, 0);
    wr(8'h10, 3);
    wr(8'h14, 3);
    ev(e_ta, 0, 0, 0);
    chk(32'(vme_berr_q), 1);
    ev(e_ma, 0, 0, 0);
    chk(32'(vme_berr_q), 1);
    ev(e_be, 0, 0, 0);
    chk(32'(pci_tabort_q), 1);
    rdc(8'h00, 32'h3800_0000);
    rdc(8'h08, 0);
    rdc(8'h0c, 0);
    wr(8'h00, 32'h3800_0000);
    rdc(8'h00, 0);
    rdc(8'h80, 0);
    chk(32'(err), 1);
  endtask
  // block write fails, log freezes, ack reopens it with one side masked
  task s_vlog;
    ev(e_ts | e_rs, 0, 0, 0);
    ev(e_vi, 32'h1230, 15'h0580, 0);
    ev(e_vi, 32'h1234, 15'h4580, 0);
    ev(e_ve, 32'h1234, 15'h4580, 32'h1400);
    chk(32'(tx_flush_q), 1);
    chk(tx_flush_end_q, 32'h1300);
    rdc(8'h18, 32'h4b);
    rdc(8'h1c, 32'h1230);
    rdc(8'h0c, 1);
    chk(32'({vme_err_irq, pci_err_irq}), 3);
    ev(e_vi | e_ve, 32'h2000, 15'h0480, 32'h2010);
    chk(32'(tx_flush_q), 1);
    rdc(8'h18, 32'hcb);
    rdc(8'h1c, 32'h1230);
    wr(8'h08, 1);
    wr(8'h0c, 1);
    wr(8'h14, 2);
    ev(e_vi | e_ve, 32'h3000, 15'h2480, 32'h3080);
    chk(tx_flush_end_q, 32'h3080);
    rdc(8'h1c, 32'h3000);
    rdc(8'h0c, 0);
    chk(32'({vme_err_irq, pci_err_irq}), 2);
    wr(8'h08, 1);
  endtask
  task s_plog;
    wr(8'h10, 0);
    for (int k = 0; k < 3; k++) begin
      ev(e_pi, 32'h5124, 15'h38 | 15'(k << 1), 0);
      ev(e_pe, 32'h5124, 15'h38 | 15'(k << 1), 0);
      chk(32'(rx_flush_q), 1);
      chk(rx_flush_end_q, xe[k]);
    end
    rdc(8'h20, 32'h87);
    rdc(8'h24, 32'h5124);
    rdc(8'h08, 0);
    wr(8'h0c, 2);
    chk(32'(pci_err_irq), 0);
  endtask
  task s_pf;
    wr(8'h04, 1);
    ev(e_ps, 32'h1054, 0, 0);
    chk(32'(pf_req_q), 1);
    chk(pf_start_q, 32'h1054);
    chk(pf_end_q, 32'h1080);
    ev(e_fa, 0, 0, 0);
    chk(32'(pf_dtack_q), 1);
    ev(e_fa, 0, 15'h1, 0);
    chk(32'({pf_dtack_q, vme_berr_q}), 0);
    ev(0, 0, 0, 0);
  endtask
  // one bad phase from the agent, then outputs and status
  task par_case(input logic ap, input logic [31:0] c, input logic [31:0] e, input logic d);
    wr(8'h00, c);
    @(posedge pclk);
    go <= 1'b1;
    pa_ap <= ap;
    as_master <= !ap;
    b64 <= d;
    @(posedge pclk);
    go <= 1'b0;
    #1;
    chk(32'(devsel_claim), 32'(!ap));
    @(posedge pclk);
    #1;
    chk(32'(ap ? {serr_o_n, serr_oe_n} : {perr_o_n, perr_oe_n}), d ? 0 : 3);
    chk(32'({par_q, par64_q}), 32'({1'b1, d}));
    chk(32'({vme_err_irq, pci_err_irq}), 0);
    rdc(8'h00, e);
    wr(8'h00, e);
  endtask
  // perr received while mastering a write, response enabled and then disabled
  task s_perr;
    for (int k = 1; k >= 0; k--) begin
      wr(8'h00, 32'(k) << 6);
      @(posedge pclk);
      as_master <= 1'b1;
      perr_n <= 1'b0;
      @(posedge pclk);
      perr_n <= 1'b1;
      rdc(8'h00, (32'(k) << 24) | (32'(k) << 6));
      wr(8'h00, 32'h0100_0000);
    end
  endtask
  task stop_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // watchdog far beyond the roughly two hundred cycles the run needs
  initial begin
    #200000;
    failures++;
    stop_test;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, evs, fl, go, pa_ap, as_master, presetn} = '0;
    {vme_addr, pci_addr, pf_addr, tx_txn_end, failures, check_count} = '0;
    {b64, perr_n} = 2'h3;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    s_cpl;
    s_vlog;
    s_plog;
    s_pf;
    par_case(1'b0, 32'h40, 32'h8100_0040, 1'b1);
    par_case(1'b0, 32'h0, 32'h8000_0000, 1'b0);
    par_case(1'b1, 32'h40, 32'h8000_0040, 1'b0);
    par_case(1'b1, 32'h140, 32'hc000_0140, 1'b1);
    s_perr;
    stop_test;
  end
endmodule
bind beh_top beh_chk u_chk (
  .pclk, .presetn, .v2p_cpl_tabort, .v2p_cpl_mabort, .p2v_cpl_berr, .vme_berr_q,
  .pci_tabort_q, .rx_store, .tx_store, .rx_wr_ack, .tx_wr_ack, .vme_pw_err, .tx_flush_q,
  .pci_pw_err, .rx_flush_q, .pf_first_ack, .pf_pci_err, .pf_dtack_q, .ad_in, .cbe_in,
  .bus64, .par_q, .par64_q, .par_in, .chk_addr, .devsel_claim
);
`default_nettype wire
